/* File: verilog/param_page_pkg.sv */
package param_page_pkg;
	// Check value arithmetic
	localparam logic [15:0] crc_poly = 16'h8005;
	localparam logic [15:0] crc_preset = 16'h4f4e;
	// Main description page offsets within one 256-byte copy
	localparam logic [7:0] page_first = 8'h00;
	localparam logic [7:0] page_last_data = 8'hfd;
	localparam logic [7:0] page_crc_lo = 8'hfe;
	localparam logic [7:0] page_crc_hi = 8'hff;
	localparam logic [7:0] warmup_off = 8'h9f;
	localparam logic [7:0] sig_last_off = 8'h03;
	localparam logic [7:0] copies_mandatory = 8'h03;
	localparam logic [2:0] sig_hits_min = 3'h2;
	// Extended page offsets
	localparam logic [15:0] ext_crc_lo = 16'h0000;
	localparam logic [15:0] ext_crc_hi = 16'h0001;
	localparam logic [15:0] ext_sig_first = 16'h0002;
	localparam logic [15:0] ext_sig_last = 16'h0005;
	localparam logic [15:0] ext_hdr_first = 16'h0010;
	localparam logic [15:0] ext_hdr_last = 16'h001f;
	localparam logic [15:0] ext_data_start = 16'h0020;
	localparam logic [31:0] ext_sig = 32'h5350_5045;
	localparam logic [7:0] sect_unused = 8'h00;
	localparam logic [7:0] sect_more = 8'h01;
	localparam logic [7:0] sect_ecc = 8'h02;
	localparam logic [3:0] sect_max = 4'h8;
	// Control registers
	localparam logic [7:0] reg_ctrl = 8'h00;
	localparam logic [7:0] reg_status = 8'h04;
	localparam logic [7:0] reg_warmup = 8'h08;
	localparam logic [7:0] reg_ext_len = 8'h0c;
	localparam logic [7:0] reg_sect = 8'h10;
	localparam int ctrl_start = 0;
	localparam int ctrl_ext = 1;
	localparam int ctrl_end = 2;
	localparam int ctrl_bus16 = 3;
	localparam logic [15:0] ext_len_rst = 16'h0100;
	localparam logic [7:0] warmup_req_rst = 8'h00;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [7:0] data;
		logic valid;
	} byte_in_t;

	function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
		logic [15:0] c;
		logic fb;
		c = crc;
		for (int i = 7; i >= 0; i--)
		begin
			fb = c[15] ^ d[i];
			c = {c[14:0], 1'b0};
			if (fb)
				c = c ^ crc_poly;
		end
		return c;
	endfunction : crc_byte
endpackage : param_page_pkg

/* File: verilog/param_page_crc_checker.sv */
// What the document requires
// R1: Warmup byte: low nibble output cycles, high nibble input; zero means unsupported.
// R2: Host never programs a warmup count above the reported count per direction.
// R3: Check value sits in bytes 254-255, computed over bytes 0 to 253.
// R4: Check value is computed bytewise in page order, bit 7 first.
// R5: Generator polynomial is 8005h.
// R6: Preset 4F4Eh, no final XOR, no bit reversal.
// R7: Bytes 256-511 hold first redundant copy, used when primary fails.
// R8: Bytes 512-767 hold second copy, used when both earlier copies fail.
// R9: Target reads redundant copies from storage, never resends first 256 bytes.
// R10: From 768, a copy exists when two of its first four bytes match signature.
// R11: Every extended page section is a multiple of sixteen bytes.
// R12: Section types: 0 unused, 1 more specifiers, 2 extended ECC, others reserved.
// R13: Nonzero section types appear in ascending order, each at most once.
// R14: Section walker stops at type zero.
// R15: Type 1 section lists type/length pairs from section 8 onward.
// R16: Type 2 section holds eight-byte ECC blocks; unspecified blocks read zero.
// R17: Multi-byte values are stored least significant byte first.
// R18: Sizes are bytes; a 16-bit host converts them to words.
// R19: Target returns zero for unused extended page fields.
// R20: Extended page: check value, signature, ten zero bytes, headers at 16.
// R21: Extended check value covers offset 2 to end, same arithmetic.
// R22: Section 0 starts at 32; lengths count 16-byte units, sections contiguous.
// R23: One byte per clock while valid; pass or fail one cycle after last check byte.
// R24: Fatal event when every available copy fails its check.
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module param_page_crc_checker #(
	parameter logic [31:0] page_sig = 32'h4547_4150 // Arbitrary value
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Register port
	input wire param_page_pkg::reg_req_t reg_req,
	output logic [31:0] rd_data,
	// Byte stream from the target
	input wire param_page_pkg::byte_in_t byte_in,
	// Results
	output logic check_pass,
	output logic check_fail,
	output logic fatal_err,
	output logic busy,
	output logic [7:0] warmup_set
);
	logic active, ext_mode, bus16, done, passed, fatal, stopped, order_err, resv_seen, more_sect, any_sect;
	logic [15:0] crc, idx, stored, ext_len, run_off, ecc_off;
	logic [7:0] copy, cand_cap, cap, wu_req, hold_type, last_type;
	logic [2:0] hits;
	logic [3:0] sect_cnt;
	logic next_active, next_ext_mode, next_bus16, next_done, next_passed, next_fatal, next_stopped;
	logic next_order_err, next_resv_seen, next_more_sect, next_any_sect, next_pass, next_fail, next_fatal_ev;
	logic [15:0] next_crc, next_idx, next_stored, next_ext_len, next_run_off, next_ecc_off;
	logic [7:0] next_copy, next_cand_cap, next_cap, next_wu_req, next_hold_type, next_last_type, next_warm;
	logic [2:0] next_hits, hits_total;
	logic [3:0] next_sect_cnt;
	logic [31:0] next_rd, sig_word;
	logic [7:0] off, d;
	logic take, start_wr, ctrl_wr, sig_match, crc_ok;

	always_comb
	begin
		off = idx[7:0];
		d = byte_in.data;
		take = active && byte_in.valid && !done; // R23
		ctrl_wr = reg_req.wr && reg_req.addr == param_page_pkg::reg_ctrl;
		start_wr = ctrl_wr && reg_req.wdata[param_page_pkg::ctrl_start];
		sig_word = ext_mode ? param_page_pkg::ext_sig : page_sig;
		sig_match = d == sig_word[{idx[1:0] - (ext_mode ? 2'h2 : 2'h0), 3'b000} +: 8];
		hits_total = hits + {2'h0, sig_match};
		crc_ok = {d, stored[7:0]} == crc; // R17
		next_active = active;
		next_ext_mode = ext_mode;
		next_bus16 = bus16;
		next_done = done;
		next_passed = passed;
		next_fatal = fatal;
		next_stopped = stopped;
		next_order_err = order_err;
		next_resv_seen = resv_seen;
		next_more_sect = more_sect;
		next_any_sect = any_sect;
		next_crc = crc;
		next_idx = idx;
		next_stored = stored;
		next_ext_len = ext_len;
		next_run_off = run_off;
		next_ecc_off = ecc_off;
		next_copy = copy;
		next_cand_cap = cand_cap;
		next_cap = cap;
		next_wu_req = wu_req;
		next_hold_type = hold_type;
		next_last_type = last_type;
		next_hits = hits;
		next_sect_cnt = sect_cnt;
		next_pass = 1'b0;
		next_fail = 1'b0;
		next_fatal_ev = 1'b0;
		if (take && !ext_mode)
		begin
			next_idx = idx + 16'h0001;
			if (off <= param_page_pkg::page_last_data)
				next_crc = param_page_pkg::crc_byte(crc, d); // R3 R4 R5
			if (off == param_page_pkg::page_crc_lo)
				next_stored[7:0] = d;
			if (off == param_page_pkg::warmup_off)
				next_cand_cap = d;
			if (copy >= param_page_pkg::copies_mandatory && off <= param_page_pkg::sig_last_off)
			begin
				next_hits = hits_total;
				if (off == param_page_pkg::sig_last_off && hits_total < param_page_pkg::sig_hits_min)
				begin
					next_fatal_ev = 1'b1; // R10 R24
					next_fatal = 1'b1;
					next_done = 1'b1;
				end
			end
			if (off == param_page_pkg::page_crc_hi)
			begin
				next_crc = param_page_pkg::crc_preset; // R6
				next_hits = 3'h0;
				if (crc_ok)
				begin
					next_pass = 1'b1;
					next_passed = 1'b1;
					next_done = 1'b1;
					next_cap = cand_cap; // R1
				end
				else
				begin
					next_fail = 1'b1;
					next_copy = copy + 8'h01; // R7 R8
				end
			end
		end
		else if (take)
		begin
			next_idx = idx + 16'h0001;
			if (idx == param_page_pkg::ext_crc_lo)
				next_stored[7:0] = d;
			if (idx >= param_page_pkg::ext_sig_first)
				next_crc = param_page_pkg::crc_byte(crc, d); // R21
			if (idx >= param_page_pkg::ext_sig_first && idx <= param_page_pkg::ext_sig_last)
				next_hits = hits_total; // R20
			if (idx >= param_page_pkg::ext_hdr_first && idx <= param_page_pkg::ext_hdr_last && !idx[0])
				next_hold_type = d;
			if (idx >= param_page_pkg::ext_hdr_first && idx <= param_page_pkg::ext_hdr_last && idx[0] && !stopped)
			begin
				if (hold_type == param_page_pkg::sect_unused)
					next_stopped = 1'b1; // R14
				else
				begin
					if (any_sect && hold_type <= last_type)
						next_order_err = 1'b1; // R13
					if (hold_type > param_page_pkg::sect_ecc)
						next_resv_seen = 1'b1; // R12
					if (hold_type == param_page_pkg::sect_more)
						next_more_sect = 1'b1; // R15
					if (hold_type == param_page_pkg::sect_ecc)
						next_ecc_off = run_off; // R16
					next_run_off = run_off + {4'h0, d, 4'h0}; // R11 R22
					next_last_type = hold_type;
					next_any_sect = 1'b1;
					next_sect_cnt = sect_cnt + 4'h1;
					if (sect_cnt + 4'h1 == param_page_pkg::sect_max)
						next_stopped = 1'b1;
				end
			end
			if (idx == ext_len - 16'h0001)
			begin
				next_done = 1'b1;
				next_pass = stored == next_crc; // R21
				next_fail = !next_pass;
				next_passed = next_pass;
			end
			if (idx == param_page_pkg::ext_crc_hi)
				next_stored[15:8] = d;
		end
		if (ctrl_wr)
		begin
			next_bus16 = reg_req.wdata[param_page_pkg::ctrl_bus16];
			if (reg_req.wdata[param_page_pkg::ctrl_end] && active && !passed && !done)
			begin
				next_fatal_ev = 1'b1; // R24
				next_fatal = 1'b1;
				next_done = 1'b1;
			end
		end
		if (start_wr)
		begin
			next_active = 1'b1;
			next_ext_mode = reg_req.wdata[param_page_pkg::ctrl_ext];
			next_crc = param_page_pkg::crc_preset; // R6
			next_idx = 16'h0000;
			next_copy = 8'h00;
			next_hits = 3'h0;
			next_done = 1'b0;
			next_passed = 1'b0;
			next_fatal = 1'b0;
			next_stopped = 1'b0;
			next_order_err = 1'b0;
			next_resv_seen = 1'b0;
			next_more_sect = 1'b0;
			next_any_sect = 1'b0;
			next_sect_cnt = 4'h0;
			next_last_type = param_page_pkg::sect_unused;
			next_run_off = param_page_pkg::ext_data_start; // R22
			next_ecc_off = 16'h0000;
		end
		if (reg_req.wr && reg_req.addr == param_page_pkg::reg_warmup)
			next_wu_req = reg_req.wdata[7:0];
		if (reg_req.wr && reg_req.addr == param_page_pkg::reg_ext_len)
			next_ext_len = reg_req.wdata[15:0];
		next_warm[3:0] = wu_req[3:0] > cap[3:0] ? cap[3:0] : wu_req[3:0]; // R2
		next_warm[7:4] = wu_req[7:4] > cap[7:4] ? cap[7:4] : wu_req[7:4]; // R2
		next_rd = 32'h0000_0000;
		if (reg_req.rd)
		begin
			unique case (reg_req.addr)
				param_page_pkg::reg_ctrl: next_rd = {28'h0000000, bus16, 1'b0, ext_mode, 1'b0};
				param_page_pkg::reg_status: next_rd = {13'h0000, hits, copy, more_sect, resv_seen, order_err,
					hits >= param_page_pkg::sig_hits_min, fatal, passed, done, active && !done};
				param_page_pkg::reg_warmup: next_rd = {8'h00, warmup_set, cap, wu_req};
				param_page_pkg::reg_ext_len: next_rd = {16'h0000, ext_len};
				param_page_pkg::reg_sect: next_rd = {8'h00, stopped, 3'h0, sect_cnt,
					bus16 ? {1'b0, ecc_off[15:1]} : ecc_off}; // R18
				default: next_rd = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			{active, ext_mode, bus16, done, passed, fatal, stopped} <= 7'h00;
			{order_err, resv_seen, more_sect, any_sect, check_pass, check_fail, fatal_err, busy} <= 8'h00;
			{crc, idx, stored, run_off, ecc_off} <= 80'h0;
			ext_len <= param_page_pkg::ext_len_rst;
			{copy, cand_cap, cap, hold_type, last_type, warmup_set} <= 48'h0;
			wu_req <= param_page_pkg::warmup_req_rst;
			hits <= 3'h0;
			sect_cnt <= 4'h0;
			rd_data <= 32'h0000_0000;
		end
		else
		begin
			{active, ext_mode, bus16, done, passed, fatal, stopped} <=
				{next_active, next_ext_mode, next_bus16, next_done, next_passed, next_fatal, next_stopped};
			{order_err, resv_seen, more_sect, any_sect} <= {next_order_err, next_resv_seen, next_more_sect, next_any_sect};
			{check_pass, check_fail, fatal_err, busy} <= {next_pass, next_fail, next_fatal_ev, next_active && !next_done};
			{crc, idx, stored, run_off, ecc_off} <= {next_crc, next_idx, next_stored, next_run_off, next_ecc_off};
			ext_len <= next_ext_len;
			{copy, cand_cap, cap, hold_type, last_type, warmup_set} <=
				{next_copy, next_cand_cap, next_cap, next_hold_type, next_last_type, next_warm};
			wu_req <= next_wu_req;
			hits <= next_hits;
			sect_cnt <= next_sect_cnt;
			rd_data <= next_rd;
		end
	end

	sequence s_last_main;
		take && !ext_mode && off == param_page_pkg::page_crc_hi;
	endsequence
	sequence s_sig_miss;
		take && !ext_mode && copy >= param_page_pkg::copies_mandatory && off == param_page_pkg::sig_last_off
			&& hits_total < param_page_pkg::sig_hits_min;
	endsequence

	property p_preset;
		@(posedge core_clk) disable iff (!arst_n) start_wr |=> crc == param_page_pkg::crc_preset;
	endproperty
	a_preset: assert property (p_preset) else $error("check register not preset on start"); // R6
	property p_crc_step;
		@(posedge core_clk) disable iff (!arst_n)
			take && !ext_mode && off <= param_page_pkg::page_last_data && !start_wr
			|=> crc == param_page_pkg::crc_byte($past(crc), $past(d));
	endproperty
	a_crc_step: assert property (p_crc_step) else $error("check register step wrong"); // R4
	property p_verdict;
		@(posedge core_clk) disable iff (!arst_n) s_last_main |=> (check_pass ^ check_fail);
	endproperty
	a_verdict: assert property (p_verdict) else $error("no verdict after last check byte"); // R23
	property p_fallback;
		@(posedge core_clk) disable iff (!arst_n)
			s_last_main ##0 !crc_ok && !start_wr |=> copy == $past(copy) + 8'h01 && busy;
	endproperty
	a_fallback: assert property (p_fallback) else $error("failed copy did not advance"); // R8
	property p_warm_limit;
		@(posedge core_clk) disable iff (!arst_n)
			##1 warmup_set[3:0] <= $past(cap[3:0]) && warmup_set[7:4] <= $past(cap[7:4]);
	endproperty
	a_warm_limit: assert property (p_warm_limit) else $error("warmup count exceeds capability"); // R2
	property p_warm_zero;
		@(posedge core_clk) disable iff (!arst_n) cap[7:4] == 4'h0 |=> warmup_set[7:4] == 4'h0;
	endproperty
	a_warm_zero: assert property (p_warm_zero) else $error("unsupported direction given warmup"); // R1
	property p_stop_hold;
		@(posedge core_clk) disable iff (!arst_n) stopped && !start_wr |=> stopped && $stable(sect_cnt);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("walker moved after stop"); // R14
	property p_sig_fatal;
		@(posedge core_clk) disable iff (!arst_n) s_sig_miss ##0 !start_wr |=> fatal_err ##1 !busy;
	endproperty
	a_sig_fatal: assert property (p_sig_fatal) else $error("missing copy not reported fatal"); // R10
	property p_fatal_pass;
		@(posedge core_clk) disable iff (!arst_n) fatal_err |-> !passed && !check_pass;
	endproperty
	a_fatal_pass: assert property (p_fatal_pass) else $error("fatal with a passing copy"); // R24
endmodule : param_page_crc_checker

/* File: tb/flash_page_model.sv */
`timescale 1ns/1ns
module flash_page_model #(
	parameter logic [31:0] page_sig = 32'h4547_4150 // Arbitrary value
) (
	// Clock
	input wire logic core_clk,
	// Byte stream to the host
	output param_page_pkg::byte_in_t byte_in
);
	logic [7:0] mem [0:1279];
	logic [7:0] last;

	initial
	begin
		byte_in = '0;
		last = 8'h00;
	end

	// Bitwise check value over mem[first..fin]
	function automatic logic [15:0] crc_of(input int first, input int fin);
		logic [15:0] c;
		c = 16'h4f4e;
		for (int i = first; i <= fin; i++)
			for (int b = 7; b >= 0; b--)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ mem[i][b]) ? 16'h8005 : 16'h0000);
		return c;
	endfunction : crc_of

	// Each copy is built in its own storage
	task automatic fill_main(input int copy, input logic [7:0] cap, input int hits, input bit bad);
		int b;
		logic [15:0] c;
		b = copy * 256;
		for (int i = 0; i < 254; i++)
			mem[b + i] = 8'(i * 3 + copy + 1);
		for (int i = 0; i < 4; i++)
			mem[b + i] = (i < hits) ? page_sig[8 * i +: 8] : ~page_sig[8 * i +: 8];
		mem[b + 159] = cap;
		c = crc_of(b, b + 253);
		mem[b + 254] = c[7:0];
		mem[b + 255] = c[15:8];
		if (bad)
			mem[b + 100] = ~mem[b + 100];
	endtask : fill_main

	// Sections: type 1 then type 2, one unit each, then end marker
	task automatic fill_ext(input int len);
		logic [15:0] c;
		for (int i = 0; i < len; i++)
			mem[i] = 8'h00;
		{mem[5], mem[4], mem[3], mem[2]} = 32'h5350_5045;
		{mem[19], mem[18], mem[17], mem[16]} = 32'h0102_0101;
		mem[48] = 8'h0a;
		c = crc_of(2, len - 1);
		mem[0] = c[7:0];
		mem[1] = c[15:8];
	endtask : fill_ext

	// Idle cycles carry the inverse of the last byte
	task automatic send(input int n, input bit slow);
		for (int i = 0; i < n; i++)
		begin
			@(posedge core_clk);
			byte_in <= '{data: mem[i], valid: 1'b1};
			last = mem[i];
			if (slow && i % 5 == 2)
			begin
				@(posedge core_clk);
				byte_in <= '{data: ~last, valid: 1'b0};
			end
		end
		@(posedge core_clk);
		byte_in <= '{data: ~last, valid: 1'b0};
	endtask : send
endmodule : flash_page_model

/* File: tb/param_page_crc_checker_bench.sv */
`timescale 1ns/1ns
module param_page_crc_checker_bench;
	localparam logic [31:0] sig = 32'h4547_4150; // Arbitrary value
	logic core_clk;
	logic arst_n;
	param_page_pkg::reg_req_t reg_req;
	logic [31:0] rd_data;
	param_page_pkg::byte_in_t byte_in;
	logic check_pass;
	logic check_fail;
	logic fatal_err;
	logic busy;
	logic [7:0] warmup_set;
	int err_total;
	int n_checks;
	int n_fail;
	logic [31:0] rd;

	param_page_crc_checker #(.page_sig(sig)) u_param_page_crc_checker (.core_clk(core_clk), .arst_n(arst_n),
		.reg_req(reg_req), .rd_data(rd_data), .byte_in(byte_in), .check_pass(check_pass),
		.check_fail(check_fail), .fatal_err(fatal_err), .busy(busy), .warmup_set(warmup_set));
	flash_page_model #(.page_sig(sig)) u_flash_page_model (.core_clk(core_clk), .byte_in(byte_in));

	always #50 core_clk = ~core_clk;

	always @(posedge core_clk)
		if (check_fail === 1'b1)
			n_fail <= n_fail + 1;

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		reg_req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		reg_req.rd <= 1'b0;
		@(posedge core_clk);
		d = rd_data;
	endtask : reg_rd

	task automatic summarize();
		if (err_total == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	task automatic t_reset();
		reg_rd(param_page_pkg::reg_ext_len, rd);
		check("ext_len", rd, 32'h0000_0100);
		reg_rd(param_page_pkg::reg_warmup, rd);
		check("warmup", rd, 32'h0000_0000);
		reg_rd(8'h20, rd);
		check("unmapped", rd, 32'h0000_0000);
		@(posedge core_clk);
		check("rd_idle", rd_data, 32'h0000_0000);
		check("outputs", {check_pass, check_fail, fatal_err, busy, warmup_set}, 32'h0000_0000);
	endtask : t_reset

	// nbad failing copies, then one good copy or a copy with too few signature hits
	task automatic t_copies(input int nbad, input int hits);
		int f;
		for (int k = 0; k < nbad; k++)
			u_flash_page_model.fill_main(k, 8'hff, 4, 1'b1);
		u_flash_page_model.fill_main(nbad, 8'h05, hits, 1'b0);
		reg_wr(param_page_pkg::reg_warmup, 32'h0000_0023);
		reg_wr(param_page_pkg::reg_ctrl, 32'h0000_0001);
		@(posedge core_clk);
		check("busy", busy, 1'b1);
		f = n_fail;
		u_flash_page_model.send(nbad * 256 + ((hits < 2) ? 4 : 256), nbad == 0);
		@(posedge core_clk);
		check("verdict", (hits < 2) ? fatal_err : check_pass, 1'b1);
		check("fails", n_fail - f, nbad);
		repeat (2) @(posedge core_clk);
		if (hits >= 2)
			check("warmup_set", warmup_set, 8'h03);
		reg_rd(param_page_pkg::reg_status, rd);
		check("copy_fatal", {rd[15:8], rd[3]}, {8'(nbad), hits < 2});
		if (hits >= 2)
		begin
			reg_rd(param_page_pkg::reg_warmup, rd);
			check("warmup_reg", rd[23:0], 24'h03_0523);
		end
	endtask : t_copies

	task automatic t_ext();
		u_flash_page_model.fill_ext(64);
		reg_wr(param_page_pkg::reg_ext_len, 32'h0000_0040);
		reg_wr(param_page_pkg::reg_ctrl, 32'h0000_000b);
		u_flash_page_model.send(64, 1'b1);
		@(posedge core_clk);
		check("ext_pass", check_pass, 1'b1);
		reg_rd(param_page_pkg::reg_sect, rd);
		check("sect", rd[23:0], 24'h82_0018);
		reg_rd(param_page_pkg::reg_status, rd);
		check("sect_flags", rd[7:5], 3'b100);
		u_flash_page_model.mem[40] = 8'h5a;
		reg_wr(param_page_pkg::reg_ctrl, 32'h0000_0003);
		u_flash_page_model.send(64, 1'b0);
		@(posedge core_clk);
		check("ext_fail", {check_pass, check_fail}, 2'b01);
	endtask : t_ext

	// A failing copy, then end of stream with no copy left
	task automatic t_end();
		int f;
		u_flash_page_model.fill_main(0, 8'hff, 4, 1'b1);
		reg_wr(param_page_pkg::reg_ctrl, 32'h0000_0001);
		f = n_fail;
		u_flash_page_model.send(256, 1'b0);
		repeat (2) @(posedge core_clk);
		check("end_fails", n_fail - f, 1);
		reg_wr(param_page_pkg::reg_ctrl, 32'h0000_000c);
		@(posedge core_clk);
		check("end_fatal", fatal_err, 1'b1);
		reg_rd(param_page_pkg::reg_status, rd);
		check("end_status", rd[15:0], 16'h010a);
		reg_rd(param_page_pkg::reg_ctrl, rd);
		check("ctrl_reg", rd, 32'h0000_0008);
	endtask : t_end

	initial
	begin
		core_clk = 1'b0;
		arst_n = 1'b0;
		reg_req = '0;
		err_total = 0;
		n_checks = 0;
		n_fail = 0;
		repeat (12) @(posedge core_clk);
		arst_n <= 1'b1;
		t_reset();
		t_copies(0, 4);
		t_copies(2, 4);
		t_copies(3, 2);
		t_copies(3, 1);
		t_end();
		t_ext();
		summarize();
	end

	initial
	begin
		repeat (100000) @(posedge core_clk);
		err_total++;
		summarize();
	end
endmodule : param_page_crc_checker_bench
